/* File: hw/sync_serial_pkg.sv */
// constants and carrier types for the synchronous serial pin timing engine
package sync_serial_pkg;

   // shift register geometry
   localparam int unsigned   DATA_BITS        = 8;
   localparam int unsigned   COUNT_BITS       = 3;
   localparam logic [2:0]    COUNT_LAST       = 3'h7;
   localparam logic [2:0]    COUNT_RESET      = 3'h0;

   // reset and idle pin levels
   localparam logic          SCLK_IDLE_LEVEL  = 1'b1;
   localparam logic          TX_RESET_LEVEL   = 1'b0;

   // core clock rate and internal serial clock half period
   localparam int unsigned   CORE_CLK_MHZ     = 200;
   localparam int unsigned   INT_HALF_NS      = 40;
   localparam int unsigned   INT_HALF_CYCLES  = (INT_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam logic [3:0]    DIV_LAST         = 4'(INT_HALF_CYCLES - 1);
   localparam logic [3:0]    DIV_RESET        = 4'h0;

   // least spacing of timer overflow ticks, in core clocks
   localparam int unsigned   OVF_MIN_PERIODS  = 4;

   // engine states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } engine_state_t;

   // static configuration from the owning unit
   typedef struct packed {
      logic master;     // 1: drive serial clock, 0: follow peer clock
      logic use_timer;  // master clock from timer overflow instead of divider
   } serial_cfg_t;

   // request from the owning unit
   typedef struct packed {
      logic                 write;  // load shift_holding_register, start transfer
      logic                 abort;  // clear busy and shift count
      logic [DATA_BITS-1:0] data;
   } serial_req_t;

endpackage : sync_serial_pkg

/* File: hw/overflow_crossing.sv */
// carries timer overflow events from the timer clock into the core clock
`timescale 1ns/100ps
module overflow_crossing
   import sync_serial_pkg::*;
(
   input  wire logic link_clk_in,
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   input  wire logic overflow_in,
   output logic      tick_out
);

   logic toggle_ff;
   logic nxt_toggle;
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic tick_ff;
   logic nxt_tick;

   // timer domain: each overflow pulse flips the toggle
   always_comb
   begin
      nxt_toggle = toggle_ff ^ overflow_in;
   end

   always_ff @(posedge link_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         toggle_ff <= 1'b0;
      else
         toggle_ff <= nxt_toggle;
   end

   // core domain: two-stage sync, then change detect
   always_comb
   begin
      nxt_tick = s2_ff ^ s3_ff;
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         s1_ff   <= 1'b0;
         s2_ff   <= 1'b0;
         s3_ff   <= 1'b0;
         tick_ff <= 1'b0;
      end
      else
      begin
         s1_ff   <= toggle_ff;
         s2_ff   <= s1_ff;
         s3_ff   <= s2_ff;
         tick_ff <= nxt_tick;
      end
   end

   assign tick_out = tick_ff;

   // overflow ticks stay at least four core clocks apart
   property p_ovf_spacing;
      @(posedge sys_clk_in) disable iff (!reset_n_in)
      tick_ff |=> !tick_ff [*3];
   endproperty
   a_ovf_spacing: assert property (p_ovf_spacing)
      else $error("timer overflow ticks closer than four core clocks");

endmodule : overflow_crossing

/* File: hw/sync_serial_engine.sv */
// pin timing engine of the eight-bit clock-synchronous serial port
// Behaviour
// - master drives serial clock, transmits on serial_out_pin, captures serial_in_pin
// - master serial clock edges change only on core clock rising edges
// - master launches bits on serial clock fall, captures on rise
// - timer overflow used as master clock spaced at least four core clocks
// - slave samples serial clock and receive pins on core clock rising edges
// - slave shifts out next bit when sampled clock falls
// - slave shifts in sampled receive bit when sampled clock rises
// - eight bits LSB first, one out and one in per bit, same register
// - write sets busy; eighth bit clears busy and pulses transfer_done_irq
// - slave ignores serial clock pulses after the eighth
// - idle clock high, transmit holds last bit; reset gives clock high, transmit low
`timescale 1ns/100ps
module sync_serial_engine
   import sync_serial_pkg::*;
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 reset_n_in,
   input  wire logic                 timer_clk_in,
   input  wire logic                 general_timer_overflow_in,
   input  wire serial_cfg_t          cfg_in,
   input  wire serial_req_t          req_in,
   input  wire logic                 serial_clock_pin_in,
   input  wire logic                 serial_in_pin_in,
   output logic                      serial_clock_pin_out,
   output logic                      serial_clock_pin_oe_out,
   output logic                      serial_out_pin_out,
   output logic                      busy_out,
   output logic [COUNT_BITS-1:0]     shift_count_out,
   output logic [DATA_BITS-1:0]      shift_holding_register_out,
   output logic                      transfer_done_irq_out
);

   // one bit in at the top, one out at the bottom
   function automatic logic [DATA_BITS-1:0] shift_in(input logic [DATA_BITS-1:0] cur, input logic bit_in);
      shift_in = {bit_in, cur[DATA_BITS-1:1]};
   endfunction : shift_in

   engine_state_t             state_ff;
   engine_state_t             nxt_state;
   logic [DATA_BITS-1:0]      shift_ff;
   logic [DATA_BITS-1:0]      nxt_shift;
   logic [COUNT_BITS-1:0]     count_ff;
   logic [COUNT_BITS-1:0]     nxt_count;
   logic                      sclk_ff;
   logic                      nxt_sclk;
   logic                      tx_ff;
   logic                      nxt_tx;
   logic                      done_ff;
   logic                      nxt_done;
   logic                      oe_ff;
   logic                      nxt_oe;
   logic [3:0]                div_ff;
   logic [3:0]                nxt_div;
   logic                      clk_s1_ff;
   logic                      clk_s2_ff;
   logic                      clk_prev_ff;
   logic                      rx_s1_ff;
   logic                      rx_s2_ff;
   logic                      ovf_tick;
   logic                      div_tick;
   logic                      master_tick;
   logic                      slave_fall;
   logic                      slave_rise;
   logic                      busy;

   // timer overflow from its own clock domain
   overflow_crossing u_ovf (
      .link_clk_in (timer_clk_in),
      .sys_clk_in  (sys_clk_in),
      .reset_n_in  (reset_n_in),
      .overflow_in (general_timer_overflow_in),
      .tick_out    (ovf_tick)
   );

   // pin sampling: two stages, then one more for edge compare
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         clk_s1_ff   <= SCLK_IDLE_LEVEL;
         clk_s2_ff   <= SCLK_IDLE_LEVEL;
         clk_prev_ff <= SCLK_IDLE_LEVEL;
         rx_s1_ff    <= 1'b0;
         rx_s2_ff    <= 1'b0;
      end
      else
      begin
         clk_s1_ff   <= serial_clock_pin_in;
         clk_s2_ff   <= clk_s1_ff;
         clk_prev_ff <= clk_s2_ff;
         rx_s1_ff    <= serial_in_pin_in;
         rx_s2_ff    <= rx_s1_ff;
      end
   end

   // edge and tick decode
   assign busy        = (state_ff == ST_BUSY);
   assign slave_fall  = clk_prev_ff & ~clk_s2_ff;
   assign slave_rise  = ~clk_prev_ff & clk_s2_ff;
   assign div_tick    = busy && (div_ff == DIV_LAST);
   assign master_tick = cfg_in.use_timer ? ovf_tick : div_tick;

   // next-state logic of the transfer engine
   always_comb
   begin
      nxt_state = state_ff;
      nxt_shift = shift_ff;
      nxt_count = count_ff;
      nxt_sclk  = sclk_ff;
      nxt_tx    = tx_ff;
      nxt_done  = 1'b0;
      nxt_oe    = cfg_in.master;
      nxt_div   = (busy && div_ff != DIV_LAST) ? 4'(div_ff + 4'h1) : DIV_RESET;
      if (req_in.write)
      begin
         nxt_state = ST_BUSY;
         nxt_shift = req_in.data;
         nxt_count = COUNT_RESET;
         nxt_sclk  = SCLK_IDLE_LEVEL;
         nxt_div   = DIV_RESET;
      end
      else if (req_in.abort)
      begin
         nxt_state = ST_IDLE;
         nxt_count = COUNT_RESET;
         nxt_sclk  = SCLK_IDLE_LEVEL;
      end
      else
      begin
         unique case (state_ff)
            ST_IDLE:
            begin
               nxt_sclk = SCLK_IDLE_LEVEL;
            end
            ST_BUSY:
            begin
               if (cfg_in.master)
               begin
                  if (master_tick)
                  begin
                     if (sclk_ff)
                     begin
                        nxt_sclk = 1'b0;
                        nxt_tx   = shift_ff[0];
                     end
                     else
                     begin
                        nxt_sclk  = 1'b1;
                        nxt_shift = shift_in(shift_ff, rx_s2_ff);
                        nxt_count = 3'(count_ff + 3'h1);
                        if (count_ff == COUNT_LAST)
                        begin
                           nxt_state = ST_IDLE;
                           nxt_done  = 1'b1;
                        end
                     end
                  end
               end
               else
               begin
                  if (slave_fall)
                     nxt_tx = shift_ff[0];
                  if (slave_rise)
                  begin
                     nxt_shift = shift_in(shift_ff, rx_s2_ff);
                     nxt_count = 3'(count_ff + 3'h1);
                     if (count_ff == COUNT_LAST)
                     begin
                        nxt_state = ST_IDLE;
                        nxt_done  = 1'b1;
                     end
                  end
               end
            end
            default:
            begin
               nxt_state = ST_IDLE;
               nxt_sclk  = SCLK_IDLE_LEVEL;
            end
         endcase
      end
   end

   // engine registers
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_ff <= ST_IDLE;
         shift_ff <= '0;
         count_ff <= COUNT_RESET;
         sclk_ff  <= SCLK_IDLE_LEVEL;
         tx_ff    <= TX_RESET_LEVEL;
         done_ff  <= 1'b0;
         oe_ff    <= 1'b0;
         div_ff   <= DIV_RESET;
      end
      else
      begin
         state_ff <= nxt_state;
         shift_ff <= nxt_shift;
         count_ff <= nxt_count;
         sclk_ff  <= nxt_sclk;
         tx_ff    <= nxt_tx;
         done_ff  <= nxt_done;
         oe_ff    <= nxt_oe;
         div_ff   <= nxt_div;
      end
   end

   // outputs straight from flops
   assign serial_clock_pin_out       = sclk_ff;
   assign serial_clock_pin_oe_out    = oe_ff;
   assign serial_out_pin_out         = tx_ff;
   assign busy_out                   = state_ff[1];
   assign shift_count_out            = count_ff;
   assign shift_holding_register_out = shift_ff;
   assign transfer_done_irq_out      = done_ff;

   // checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   property p_master_oe;
      cfg_in.master |=> oe_ff;
   endproperty
   a_master_oe: assert property (p_master_oe)
      else $error("master mode not driving serial clock pin");

   property p_master_edge_tick;
      cfg_in.master && busy && !req_in.write && !req_in.abort && !master_tick |=> $stable(sclk_ff);
   endproperty
   a_master_edge_tick: assert property (p_master_edge_tick)
      else $error("master serial clock moved without a tick");

   property p_master_launch;
      cfg_in.master && busy && master_tick && sclk_ff && !req_in.write && !req_in.abort
         |=> !sclk_ff && tx_ff == $past(shift_ff[0]);
   endproperty
   a_master_launch: assert property (p_master_launch)
      else $error("master bit not launched on serial clock fall");

   property p_master_capture;
      cfg_in.master && busy && master_tick && !sclk_ff && !req_in.write && !req_in.abort
         |=> sclk_ff && shift_ff == {$past(rx_s2_ff), $past(shift_ff[7:1])};
   endproperty
   a_master_capture: assert property (p_master_capture)
      else $error("master bit not captured on serial clock rise");

   property p_write_busy;
      req_in.write |=> busy_out && shift_count_out == COUNT_RESET;
   endproperty
   a_write_busy: assert property (p_write_busy)
      else $error("write did not start a transfer");

   property p_done_pulse;
      $fell(busy_out) && !$past(req_in.abort) |-> transfer_done_irq_out ##1 !transfer_done_irq_out;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("transfer end without a one-cycle done pulse");

   property p_idle_frozen;
      !busy && !req_in.write |=> $stable(shift_ff) && sclk_ff;
   endproperty
   a_idle_frozen: assert property (p_idle_frozen)
      else $error("idle engine moved on a clock pulse");

   property p_slave_fall;
      !cfg_in.master && busy && slave_fall && !req_in.write && !req_in.abort
         |=> tx_ff == $past(shift_ff[0]);
   endproperty
   a_slave_fall: assert property (p_slave_fall)
      else $error("slave bit not presented on sampled clock fall");

   property p_slave_rise;
      !cfg_in.master && busy && slave_rise && !req_in.write && !req_in.abort
         |=> shift_ff == {$past(rx_s2_ff), $past(shift_ff[7:1])} ##0 count_ff == $past(count_ff) + 3'h1;
   endproperty
   a_slave_rise: assert property (p_slave_rise)
      else $error("slave bit not taken on sampled clock rise");

   property p_idle_tx_hold;
      !busy && !req_in.write |=> $stable(tx_ff);
   endproperty
   a_idle_tx_hold: assert property (p_idle_tx_hold)
      else $error("transmit pin changed between transfers");

   c_master_done: cover property (cfg_in.master && $fell(busy_out) && transfer_done_irq_out);
   c_slave_done:  cover property (!cfg_in.master && $fell(busy_out) && transfer_done_irq_out);
   c_abort:       cover property (busy && req_in.abort);
   c_timer_clock: cover property (cfg_in.master && cfg_in.use_timer && busy && ovf_tick);

endmodule : sync_serial_engine

/* File: verification/serial_peer_model.sv */
// behavioural model of the external serial peer sharing clock and data
`timescale 1ns/100ps
module serial_peer_model (
   input  wire logic  clock_wire_in,
   input  wire logic  master_in,
   input  wire logic  tx_pin_in,
   output logic       clock_drive_out,
   output logic       rx_pin_out,
   output logic [7:0] got_out
);
   logic [7:0] send_byte;
   int         idx;

   // idle: clock released high, data low
   initial
   begin
      clock_drive_out = 1'b1;
      rx_pin_out      = 1'b0;
      got_out         = 8'h00;
      send_byte       = 8'h00;
      idx             = 0;
   end

   // arm the next byte, bit zero up front
   task automatic load(input logic [7:0] b);
      send_byte  = b;
      idx        = 0;
      rx_pin_out = b[0];
   endtask : load

   // device clocks us: take its bit at the rise, then present our next bit
   always @(posedge clock_wire_in)
   begin
      if (master_in)
      begin
         got_out = {tx_pin_in, got_out[7:1]};
         idx++;
         #2;
         rx_pin_out = (idx < 8) ? send_byte[idx[2:0]] : ~rx_pin_out;
      end
   end

   // we clock the device: data set mid-low, its bit taken at our rise
   task automatic frame(input int pulses, input int half_ns);
      for (int i = 0; i < pulses; i++)
      begin
         clock_drive_out = 1'b0;
         #(half_ns / 2);
         rx_pin_out = (i < 8) ? send_byte[i[2:0]] : ~rx_pin_out;
         #(half_ns - half_ns / 2);
         clock_drive_out = 1'b1;
         got_out = {tx_pin_in, got_out[7:1]};
         #half_ns;
      end
      rx_pin_out = ~rx_pin_out;  // released line carries no stale bit
   endtask : frame
endmodule : serial_peer_model

/* File: verification/sync_serial_engine_tb_top.sv */
// self-checking bench for the synchronous serial pin timing engine
`timescale 1ns/100ps
module sync_serial_engine_tb_top;
   import sync_serial_pkg::*;

   logic                  sys_clk_in;
   logic                  reset_n_in;
   logic                  timer_clk_in;
   logic                  ovf;
   logic                  ovf_en;
   serial_cfg_t           cfg;
   serial_req_t           req;
   logic                  clk_out;
   logic                  clk_oe;
   logic                  tx_pin;
   logic                  busy;
   logic                  irq;
   logic                  peer_clk;
   logic                  rx_pin;
   logic                  clk_wire;
   logic [COUNT_BITS-1:0] count;
   logic [DATA_BITS-1:0]  shift;
   logic [DATA_BITS-1:0]  peer_got;
   logic [15:0]           note;
   logic [15:0]           exp_q[$];
   int                    failures;
   int                    tests_run;
   int                    cycles;
   int                    seed;

   // core clock and unrelated timer clock
   initial
   begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   initial
   begin
      timer_clk_in = 1'b0;
      #13;
      forever #40 timer_clk_in = ~timer_clk_in;
   end

   // overflow every other timer cycle, far above four core clocks
   initial ovf = 1'b0;
   always @(negedge timer_clk_in) ovf <= ovf_en & ~ovf;

   // clock pin level: device when enabled, else peer (idles high)
   assign clk_wire = clk_oe ? clk_out : peer_clk;

   sync_serial_engine sync_serial_engine_inst (
      .sys_clk_in                 (sys_clk_in),
      .reset_n_in                 (reset_n_in),
      .timer_clk_in               (timer_clk_in),
      .general_timer_overflow_in  (ovf),
      .cfg_in                     (cfg),
      .req_in                     (req),
      .serial_clock_pin_in        (clk_wire),
      .serial_in_pin_in           (rx_pin),
      .serial_clock_pin_out       (clk_out),
      .serial_clock_pin_oe_out    (clk_oe),
      .serial_out_pin_out         (tx_pin),
      .busy_out                   (busy),
      .shift_count_out            (count),
      .shift_holding_register_out (shift),
      .transfer_done_irq_out      (irq)
   );

   serial_peer_model peer_inst (
      .clock_wire_in   (clk_wire),
      .master_in       (clk_oe),
      .tx_pin_in       (tx_pin),
      .clock_drive_out (peer_clk),
      .rx_pin_out      (rx_pin),
      .got_out         (peer_got)
   );

   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   // counts, verdict, end of run
   task automatic print_verdict;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   // hang guard
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         print_verdict();
      end
   end

   // pin clock moves only just after a core rising edge
   always @(clk_out)
      if (reset_n_in === 1'b1) check(8'(sys_clk_in), 8'h01, "clock edge off core edge");

   // completion monitor takes the oldest note
   always @(negedge sys_clk_in)
   begin
      if (irq === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(8'(irq), 8'h00, "unexpected completion");
         else
         begin
            note = exp_q.pop_front();
            check(shift, note[15:8], "received byte");
            check(peer_got, note[7:0], "byte at peer");
            // idle after the last bit: not busy, count zero, clock high, transmit holds bit seven
            check(8'({busy, count, clk_out, tx_pin}), 8'({4'h0, 1'b1, note[7]}), "end state");
         end
      end
   end

   // one transfer: master or slave, random bytes both ways
   task automatic xfer(input logic is_master, input logic use_tmr, input int pulses, input int half_ns);
      logic [7:0] tx_b;
      logic [7:0] rx_b;
      int         n;
      tx_b = 8'($random(seed));
      rx_b = 8'($random(seed));
      @(negedge sys_clk_in);
      cfg = '{master: is_master, use_timer: use_tmr};
      ovf_en = use_tmr;
      peer_inst.load(rx_b);
      exp_q.push_back({rx_b, tx_b});
      @(negedge sys_clk_in);
      req = '{write: 1'b1, abort: 1'b0, data: tx_b};
      @(negedge sys_clk_in);
      req.write = 1'b0;
      check(8'({busy, count}), 8'h08, "busy after write");
      check(8'(clk_oe), 8'(is_master), "clock drive enable");
      if (!is_master) peer_inst.frame(pulses, half_ns);
      n = 0;
      while (busy !== 1'b0 && n < 2000)
      begin
         @(negedge sys_clk_in);
         n++;
      end
      check(8'(n < 2000), 8'h01, "transfer did not end");
      repeat (4) @(negedge sys_clk_in);
      check(shift, rx_b, "byte kept after frame");
      check(8'({busy, count, clk_out, tx_pin}), 8'({4'h0, 1'b1, tx_b[7]}), "idle pins");
   endtask : xfer

   // main sequence
   initial
   begin
      seed = 32'hc5e85eae;
      reset_n_in = 1'b0;
      cfg = '0;
      req = '0;
      ovf_en = 1'b0;
      failures = 0;
      tests_run = 0;
      cycles = 0;
      repeat (20) @(negedge sys_clk_in);
      check({clk_out, tx_pin, busy, irq, clk_oe, count}, 8'h80, "reset levels");
      reset_n_in = 1'b1;
      // master from divider, then from timer overflow
      repeat (3) xfer(1'b1, 1'b0, 8, 0);
      repeat (2) xfer(1'b1, 1'b1, 8, 0);
      // slave at two rates, then surplus pulses
      xfer(1'b0, 1'b0, 8, 40);
      xfer(1'b0, 1'b0, 8, 80);
      xfer(1'b0, 1'b0, 10, 40);
      // abort in mid-transfer
      cfg = '{master: 1'b1, use_timer: 1'b0};
      @(negedge sys_clk_in);
      req = '{write: 1'b1, abort: 1'b0, data: 8'($random(seed))};
      @(negedge sys_clk_in);
      req.write = 1'b0;
      repeat (37) @(negedge sys_clk_in);
      req.abort = 1'b1;
      @(negedge sys_clk_in);
      req.abort = 1'b0;
      check(8'({busy, count, clk_out}), 8'h01, "abort");
      repeat (40) @(negedge sys_clk_in);
      // reset in mid-transfer, then one more master byte
      req = '{write: 1'b1, abort: 1'b0, data: 8'($random(seed))};
      @(negedge sys_clk_in);
      req.write = 1'b0;
      repeat (21) @(negedge sys_clk_in);
      reset_n_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      check({clk_out, tx_pin, busy, irq, clk_oe, count}, 8'h80, "mid-run reset levels");
      reset_n_in = 1'b1;
      xfer(1'b1, 1'b0, 8, 0);
      // every noted transfer must have completed
      check(8'(exp_q.size()), 8'h00, "completions missing");
      repeat (40) @(negedge sys_clk_in);
      print_verdict();
   end
endmodule : sync_serial_engine_tb_top
